// file: verilog/ulsu_map.svh
// Register offsets, field positions, reset values and sizes of the line status block
`ifndef ULSU_MAP_SVH
`define ULSU_MAP_SVH

// ==========================================================
// Register byte offsets (haddr[7:0])
`define ULSU_OFF_DATA       8'h00
`define ULSU_OFF_IER        8'h04
`define ULSU_OFF_FCR        8'h08
`define ULSU_OFF_LSR        8'h0c

// ==========================================================
// Line status field positions
`define ULSU_LSR_FIFO_ERR   7
`define ULSU_LSR_TX_EMPTY   6
`define ULSU_LSR_THR_EMPTY  5
`define ULSU_LSR_BREAK      4
`define ULSU_LSR_FRAME_ERR  3

// ==========================================================
// Control field positions
`define ULSU_IER_THRE       1
`define ULSU_FCR_ENABLE     0
`define ULSU_FCR_RX_RESET   1
`define ULSU_FCR_TX_RESET   2

// ==========================================================
// Reset values
`define ULSU_IER_RESET      8'h00
`define ULSU_FCR_RESET      8'h00
`define ULSU_HRDATA_RESET   32'h0000_0000

// ==========================================================
// Default FIFO size
`define ULSU_FIFO_AW        4

`endif

// file: verilog/ulsu_pkg.sv
// Types shared by the line status block modules
package ulsu_pkg;

  // ==========================================================
  // Register selection
  typedef enum logic [2:0] {
    REG_DATA,
    REG_IER,
    REG_FCR,
    REG_LSR,
    REG_NONE
  } ulsu_reg_t;

  // ==========================================================
  // One receive FIFO entry with its error indications
  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } ulsu_rx_entry_t;

  // Address decode used by read and write paths
  function automatic ulsu_reg_t ulsu_decode(input logic [7:0] addr);
    case (addr)
      8'h00:   ulsu_decode = REG_DATA;
      8'h04:   ulsu_decode = REG_IER;
      8'h08:   ulsu_decode = REG_FCR;
      8'h0c:   ulsu_decode = REG_LSR;
      default: ulsu_decode = REG_NONE;
    endcase
  endfunction

endpackage

// file: verilog/ulsu_fifo_if.sv
// Interface between the top module and one FIFO
`timescale 1ns/1ps
interface ulsu_fifo_if #(
  parameter int W  = 8,
  parameter int AW = 4
);
  logic          push;
  logic [W-1:0]  wdata;
  logic          pop;
  logic          flush;
  logic [W-1:0]  rdata;
  logic          empty;
  logic          full;
  logic [AW:0]   count;

  // Owner side drives requests
  modport user (output push, wdata, pop, flush, input rdata, empty, full, count);
  // FIFO side answers
  modport fifo (input push, wdata, pop, flush, output rdata, empty, full, count);
endinterface

// file: verilog/ulsu_mem.sv
// Small dual port memory with registered, write-through read data
`timescale 1ns/1ps
module ulsu_mem #(
  parameter int W  = 8,
  parameter int AW = 4
) (
  // Clock
  input  wire logic          clock_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  // Read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);
  logic [W-1:0] mem_reg [2**AW];

  // Storage write
  always_ff @(posedge clock_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
  end

  // Registered read, new data passed through on same address
  always_ff @(posedge clock_i) begin
    if (we_i && (waddr_i == raddr_i)) begin
      rdata_o <= wdata_i;
    end else begin
      rdata_o <= mem_reg[raddr_i];
    end
  end
endmodule

// file: verilog/ulsu_fifo.sv
// Show-ahead FIFO: head entry always present on rdata
`timescale 1ns/1ps
module ulsu_fifo #(
  parameter int W  = 8,
  parameter int AW = 4
) (
  // Clock and reset
  input  wire logic   clock_i,
  input  wire logic   resetn_i,
  // Owner connection
  ulsu_fifo_if.fifo   f
);
  localparam int unsigned DEPTH = 2**AW;

  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0]   count_reg;
  logic [AW-1:0] rd_ptr_next;
  logic          do_push;
  logic          do_pop;

  if (AW < 1 || AW > 8) begin : g_bad_aw
    $error("ulsu_fifo: AW must be 1..8");
  end

  // Accepted requests
  assign do_push     = f.push & ~f.full & ~f.flush;
  assign do_pop      = f.pop & ~f.empty & ~f.flush;
  assign rd_ptr_next = f.flush ? '0 : rd_ptr_reg + AW'(do_pop);

  // Pointers and fill count
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (f.flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(do_push);
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Status
  assign f.empty = (count_reg == '0);
  assign f.full  = (count_reg == (AW+1)'(DEPTH));
  assign f.count = count_reg;

  ulsu_mem #(.W(W), .AW(AW)) u_mem (
    .clock_i (clock_i),
    .we_i    (do_push),
    .waddr_i (wr_ptr_reg),
    .wdata_i (f.wdata),
    .raddr_i (rd_ptr_next),
    .rdata_o (f.rdata)
  );

  // Count bounded by depth
  count_bound_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    count_reg <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

// file: verilog/ulsu_top.sv
// Line status logic of a UART with AHB-Lite register access
`include "ulsu_map.svh"
`timescale 1ns/1ps
module ulsu_top #(
  parameter int AW = `ULSU_FIFO_AW
) (
  // Clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RESETN_I,
  // AHB-Lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // Serial receiver
  input  wire logic        RX_FRAME_I,
  input  wire logic [7:0]  RX_DATA_I,
  input  wire logic        RX_PARITY_ERR_I,
  input  wire logic        RX_STOP_OK_I,
  input  wire logic        RX_ALL_LOW_I,
  input  wire logic        RX_LINE_I,
  // Serial transmitter
  input  wire logic        TX_BUSY_I,
  output logic             TX_LOAD_O,
  output logic      [7:0]  TX_DATA_O,
  // Interrupt
  output logic             IRQ_O
);

  // ==========================================================
  // Declarations
  localparam int RXW = $bits(ulsu_pkg::ulsu_rx_entry_t);

  ulsu_fifo_if #(.W(RXW), .AW(AW)) rx_f ();
  ulsu_fifo_if #(.W(8),   .AW(AW)) tx_f ();

  ulsu_pkg::ulsu_rx_entry_t rx_head;
  ulsu_pkg::ulsu_rx_entry_t rx_entry;
  ulsu_pkg::ulsu_reg_t      addr_sel;
  ulsu_pkg::ulsu_reg_t      wr_sel_reg;

  logic       wr_pend_reg;
  logic [7:0] ier_reg;
  logic [7:0] fcr_reg;
  logic       fifo_mode;
  logic       accept;
  logic       rd_acc;
  logic       lsr_read;
  logic       data_read;
  logic       wr_data;
  logic       wr_fcr;
  logic       fifo_err_reg;
  logic       fe_sticky_reg;
  logic       bi_sticky_reg;
  logic       brk_hold_reg;
  logic       rx_brk;
  logic       rx_suppress;
  logic       rx_push;
  logic       rx_err;
  logic       tx_push;
  logic       tx_load_next;
  logic       tx_empty;
  logic       thr_empty;
  logic [7:0] lsr_val;

  if (AW < 1 || AW > 8) begin : g_bad_aw
    $error("ulsu_top: AW must be 1..8");
  end

  // ==========================================================
  // AHB-Lite decode
  assign accept    = HSEL_I & HREADY_I & HTRANS_I[1];
  assign addr_sel  = ulsu_pkg::ulsu_decode(HADDR_I[7:0]);
  assign rd_acc    = accept & ~HWRITE_I;
  assign lsr_read  = rd_acc & (addr_sel == ulsu_pkg::REG_LSR);
  assign data_read = rd_acc & (addr_sel == ulsu_pkg::REG_DATA);
  assign wr_data   = wr_pend_reg & (wr_sel_reg == ulsu_pkg::REG_DATA);
  assign wr_fcr    = wr_pend_reg & (wr_sel_reg == ulsu_pkg::REG_FCR);
  assign fifo_mode = fcr_reg[`ULSU_FCR_ENABLE];

  // Write address phase capture
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wr_pend_reg <= 1'b0;
      wr_sel_reg  <= ulsu_pkg::REG_NONE;
    end else begin
      wr_pend_reg <= accept & HWRITE_I;
      wr_sel_reg  <= addr_sel;
    end
  end

  // Zero wait state, always OKAY
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end

  // Read data captured at the address phase edge
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      HRDATA_O <= `ULSU_HRDATA_RESET;
    end else if (rd_acc) begin
      case (addr_sel)
        ulsu_pkg::REG_DATA: HRDATA_O <= {24'h00_0000, rx_f.empty ? 8'h00 : rx_head.data};
        ulsu_pkg::REG_IER:  HRDATA_O <= {24'h00_0000, ier_reg};
        ulsu_pkg::REG_FCR:  HRDATA_O <= {24'h00_0000, fcr_reg};
        ulsu_pkg::REG_LSR:  HRDATA_O <= {24'h00_0000, lsr_val};
        default:            HRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  // Control registers, FIFO reset bits self clear
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ier_reg <= `ULSU_IER_RESET;
      fcr_reg <= `ULSU_FCR_RESET;
    end else if (wr_pend_reg) begin
      if (wr_sel_reg == ulsu_pkg::REG_IER) begin
        ier_reg <= HWDATA_I[7:0];
      end
      if (wr_sel_reg == ulsu_pkg::REG_FCR) begin
        fcr_reg <= {7'h00, HWDATA_I[`ULSU_FCR_ENABLE]};
      end
    end
  end

  // Flush on mode change or explicit reset bit
  assign rx_f.flush = wr_fcr & (HWDATA_I[`ULSU_FCR_RX_RESET] | (HWDATA_I[`ULSU_FCR_ENABLE] != fifo_mode));
  assign tx_f.flush = wr_fcr & (HWDATA_I[`ULSU_FCR_TX_RESET] | (HWDATA_I[`ULSU_FCR_ENABLE] != fifo_mode));

  // ==========================================================
  // Receive path
  assign rx_brk      = RX_FRAME_I & RX_ALL_LOW_I;
  assign rx_suppress = rx_brk & brk_hold_reg;
  assign rx_push     = RX_FRAME_I & ~rx_suppress & (fifo_mode ? ~rx_f.full : rx_f.empty);
  assign rx_err      = RX_PARITY_ERR_I | ~RX_STOP_OK_I | rx_brk;

  // Entry with its own error indications
  always_comb begin
    rx_entry      = '0;
    rx_entry.data = rx_brk ? 8'h00 : RX_DATA_I;
    rx_entry.pe   = RX_PARITY_ERR_I;
    rx_entry.fe   = ~RX_STOP_OK_I;
    rx_entry.brk  = rx_brk;
  end

  assign rx_f.push  = rx_push;
  assign rx_f.wdata = rx_entry;
  assign rx_f.pop   = data_read;
  assign rx_head    = rx_f.rdata;

  // One break character per low period, rearmed by a high line
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      brk_hold_reg <= 1'b0;
    end else if (rx_brk) begin
      brk_hold_reg <= 1'b1;
    end else if (RX_LINE_I) begin
      brk_hold_reg <= 1'b0;
    end
  end

  // Summary of errors pushed into the receive FIFO in FIFO mode since the last status read or flush, set beats read clear
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      fifo_err_reg <= 1'b0;
    end else if (rx_push & rx_err & fifo_mode & ~rx_f.flush) begin
      fifo_err_reg <= 1'b1;
    end else if (lsr_read | rx_f.flush) begin
      fifo_err_reg <= 1'b0;
    end
  end

  // Non-FIFO framing and break flags, set beats read clear
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      fe_sticky_reg <= 1'b0;
      bi_sticky_reg <= 1'b0;
    end else begin
      fe_sticky_reg <= (rx_push & ~RX_STOP_OK_I) | (fe_sticky_reg & ~lsr_read);
      bi_sticky_reg <= (rx_push & rx_brk) | (bi_sticky_reg & ~lsr_read);
    end
  end

  // ==========================================================
  // Transmit path
  assign tx_push      = wr_data & (fifo_mode ? ~tx_f.full : tx_f.empty);
  assign tx_load_next = ~tx_f.empty & ~TX_BUSY_I & ~TX_LOAD_O;
  assign tx_f.push    = tx_push;
  assign tx_f.wdata   = HWDATA_I[7:0];
  assign tx_f.pop     = tx_load_next;

  // Hand character to the shift register
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      TX_LOAD_O <= 1'b0;
      TX_DATA_O <= 8'h00;
    end else begin
      TX_LOAD_O <= tx_load_next;
      if (tx_load_next) begin
        TX_DATA_O <= tx_f.rdata;
      end
    end
  end

  // Holding and transmitter empty
  assign thr_empty = tx_f.empty;
  assign tx_empty  = tx_f.empty & ~TX_BUSY_I & ~TX_LOAD_O;

  // Interrupt on empty holding register
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= ier_reg[`ULSU_IER_THRE] & thr_empty;
    end
  end

  // ==========================================================
  // Line status value
  always_comb begin
    lsr_val = 8'h00;
    lsr_val[`ULSU_LSR_FIFO_ERR]  = fifo_mode & fifo_err_reg;
    lsr_val[`ULSU_LSR_TX_EMPTY]  = tx_empty;
    lsr_val[`ULSU_LSR_THR_EMPTY] = thr_empty;
    lsr_val[`ULSU_LSR_BREAK]     = fifo_mode ? (~rx_f.empty & rx_head.brk) : bi_sticky_reg;
    lsr_val[`ULSU_LSR_FRAME_ERR] = fifo_mode ? (~rx_f.empty & rx_head.fe) : fe_sticky_reg;
  end

  // ==========================================================
  // FIFO instances
  ulsu_fifo #(.W(RXW), .AW(AW)) u_rx_fifo (
    .clock_i  (CLOCK_I),
    .resetn_i (RESETN_I),
    .f        (rx_f)
  );

  ulsu_fifo #(.W(8), .AW(AW)) u_tx_fifo (
    .clock_i  (CLOCK_I),
    .resetn_i (RESETN_I),
    .f        (tx_f)
  );

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);

  err_summary_set_a: assert property (
    rx_push && rx_err && fifo_mode && !rx_f.flush |=> lsr_val[7])
    else $error("error summary not set by errored character");

  err_summary_clr_a: assert property (
    lsr_read && !(rx_push && rx_err) |=> !fifo_err_reg)
    else $error("error summary not cleared by status read");

  temt_busy_a: assert property (
    TX_LOAD_O || !tx_f.empty |-> !lsr_val[6])
    else $error("transmitter empty while a character is held");

  temt_idle_a: assert property (
    tx_f.empty && !TX_BUSY_I && !TX_LOAD_O |-> lsr_val[6])
    else $error("transmitter empty missing while idle");

  thre_move_a: assert property (
    tx_load_next && tx_f.count == 1 && !tx_push |=> lsr_val[5] ##1 !tx_load_next)
    else $error("holding empty not set after move to shift register");

  thre_write_a: assert property (
    tx_push |=> !lsr_val[5])
    else $error("holding empty not cleared by host write");

  thre_irq_a: assert property (
    ier_reg[1] && thr_empty |=> IRQ_O)
    else $error("interrupt missing for empty holding register");

  // Break character stored, line not yet back high
  logic brk_stored_reg;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      brk_stored_reg <= 1'b0;
    end else if (rx_push && rx_brk) begin
      brk_stored_reg <= 1'b1;
    end else if (RX_LINE_I) begin
      brk_stored_reg <= 1'b0;
    end
  end

  break_once_a: assert property (
    rx_brk && brk_stored_reg |-> !rx_push)
    else $error("second break character stored for one break");

  break_flag_a: assert property (
    rx_push && rx_brk && rx_f.empty && !rx_f.pop && !rx_f.flush |=> lsr_val[4])
    else $error("break flag not set after break frame");

  frame_head_a: assert property (
    fifo_mode && rx_push && !RX_STOP_OK_I && rx_f.empty && !rx_f.pop && !rx_f.flush
      |=> lsr_val[3] until_with (rx_f.pop || rx_f.flush))
    else $error("framing error not reported for head character");

  reset_zero_a: assert property (
    $rose(RESETN_I) |-> !fifo_err_reg && !fe_sticky_reg && !bi_sticky_reg)
    else $error("status flags not zero after reset");

  tx_load_c:   cover property (tx_load_next ##1 TX_LOAD_O);
  break_c:     cover property (rx_push && rx_brk && fifo_mode);
  err_read_c:  cover property (fifo_err_reg && lsr_read);
  irq_c:       cover property ($rose(IRQ_O));
endmodule

// file: tb/ulsu_tx_model.sv
// Transmit shift register model that answers the block's load pulses
`timescale 1ns/1ps
module ulsu_tx_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Load from the block
  input  wire logic       load_i,
  input  wire logic [7:0] data_i,
  // Bench controls
  input  wire logic       stall_i,
  input  wire logic       slow_i,
  // Shift register occupied
  output logic            busy_o
);
  logic [7:0] left_reg;
  logic [7:0] seen [0:7];
  int         cnt;

  // Occupied while shifting or while the bench holds it
  assign busy_o = stall_i | (left_reg != 8'h00);

  // Busy from the cycle after a load, slow or prompt
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      left_reg <= 8'h00;
      cnt      <= 0;
    end else if (load_i) begin
      left_reg         <= slow_i ? 8'h28 : 8'h02;
      seen[cnt[2:0]]   <= data_i;
      cnt              <= cnt + 1;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
endmodule

// file: tb/tb_top.sv
// Self-checking testbench of the line status block
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        rstn     = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        rx_frame = 1'b0;
  logic [7:0]  rx_data  = 8'h00;
  logic        rx_pe    = 1'b0;
  logic        rx_sok   = 1'b1;
  logic        rx_low   = 1'b0;
  logic        rx_line  = 1'b1;
  logic        tx_busy;
  logic        tx_load;
  logic [7:0]  tx_data;
  logic        irq;
  logic        stall    = 1'b0;
  logic        slow     = 1'b1;
  logic [31:0] rd;
  int          fails    = 0;
  int          n_checks = 0;

  // ==========================================================
  // Clock, design and transmit partner
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ulsu_top #(.AW(4)) DUT (
    .CLOCK_I(clk), .RESETN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .RX_FRAME_I(rx_frame), .RX_DATA_I(rx_data), .RX_PARITY_ERR_I(rx_pe),
    .RX_STOP_OK_I(rx_sok), .RX_ALL_LOW_I(rx_low), .RX_LINE_I(rx_line),
    .TX_BUSY_I(tx_busy), .TX_LOAD_O(tx_load), .TX_DATA_O(tx_data), .IRQ_O(irq)
  );

  ulsu_tx_model tx (
    .clk_i(clk), .rstn_i(rstn), .load_i(tx_load), .data_i(tx_data),
    .stall_i(stall), .slow_i(slow), .busy_o(tx_busy)
  );

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One single AHB transfer, read data kept in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // One received frame; a break frame holds the line low
  task automatic rx(input logic [7:0] d, input logic pe, input logic sok, input logic brk);
    @(posedge clk);
    rx_frame <= 1'b1;
    rx_data  <= d;
    rx_pe    <= pe;
    rx_sok   <= sok;
    rx_low   <= brk;
    rx_line  <= !brk;
    @(posedge clk);
    rx_frame <= 1'b0;
  endtask

  task automatic wait_cnt(input int n);
    for (int i = 0; i < 400 && tx.cnt != n; i++) @(posedge clk);
    chk(tx.cnt, n);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 100 && tx_busy !== 1'b0; i++) @(posedge clk);
    chk({31'h0, tx_busy}, 32'h0);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    rdchk(8'h0c, 32'h60);
    rdchk(8'h10, 32'h0);
    rdchk(8'h04, 32'h0);
  endtask

  task automatic t_plain_tx();
    stall <= 1'b1;
    bus(1'b1, 8'h04, 32'h2);
    rdchk(8'h0c, 32'h20);
    chk(irq, 1'b1);
    bus(1'b1, 8'h00, 32'ha5);
    rdchk(8'h0c, 32'h00);
    chk(irq, 1'b0);
    stall <= 1'b0;
    wait_cnt(1);
    chk(tx.seen[0], 8'ha5);
    rdchk(8'h0c, 32'h20);
    chk(irq, 1'b1);
    wait_idle();
    rdchk(8'h0c, 32'h60);
    bus(1'b1, 8'h04, 32'h0);
    rdchk(8'h04, 32'h0);
    chk(irq, 1'b0);
  endtask

  task automatic t_plain_rx();
    rx(8'h31, 1'b0, 1'b0, 1'b0);
    rdchk(8'h00, 32'h31);
    rdchk(8'h0c, 32'h68);
    rdchk(8'h0c, 32'h60);
    rx(8'h00, 1'b0, 1'b1, 1'b1);
    rdchk(8'h0c, 32'h70);
    rdchk(8'h00, 32'h00);
    rdchk(8'h0c, 32'h60);
  endtask

  task automatic t_fifo_tx();
    bus(1'b1, 8'h08, 32'h1);
    stall <= 1'b1;
    rdchk(8'h0c, 32'h20);
    bus(1'b1, 8'h00, 32'h11);
    rdchk(8'h0c, 32'h00);
    bus(1'b1, 8'h00, 32'h22);
    bus(1'b1, 8'h00, 32'h33);
    stall <= 1'b0;
    wait_cnt(2);
    rdchk(8'h0c, 32'h00);
    wait_cnt(4);
    rdchk(8'h0c, 32'h20);
    wait_idle();
    rdchk(8'h0c, 32'h60);
    for (int i = 1; i < 4; i++) chk(tx.seen[i], 8'h11 * i);
    slow <= 1'b0;
    bus(1'b1, 8'h00, 32'h44);
    wait_cnt(5);
    wait_idle();
    rdchk(8'h0c, 32'h60);
    chk(tx.seen[4], 8'h44);
  endtask

  task automatic t_fifo_rx();
    rx(8'h41, 1'b0, 1'b1, 1'b0);
    rx(8'h42, 1'b0, 1'b0, 1'b0);
    rx(8'h00, 1'b0, 1'b1, 1'b1);
    rx(8'h00, 1'b0, 1'b1, 1'b1);
    rdchk(8'h0c, 32'he0);
    rdchk(8'h0c, 32'h60);
    rdchk(8'h00, 32'h41);
    rdchk(8'h0c, 32'h68);
    rdchk(8'h00, 32'h42);
    rdchk(8'h0c, 32'h70);
    rdchk(8'h00, 32'h00);
    rdchk(8'h0c, 32'h60);
    rx(8'h43, 1'b1, 1'b1, 1'b0);
    rdchk(8'h0c, 32'he0);
    rdchk(8'h00, 32'h43);
    rdchk(8'h0c, 32'h60);
    // Explicit receive and transmit flush empties both FIFOs
    rx(8'h44, 1'b0, 1'b0, 1'b0);
    stall <= 1'b1;
    bus(1'b1, 8'h00, 32'h55);
    bus(1'b1, 8'h08, 32'h7);
    rdchk(8'h0c, 32'h20);
    rdchk(8'h00, 32'h00);
    stall <= 1'b0;
    repeat (4) @(posedge clk);
    chk(tx.cnt, 5);
  endtask

  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_plain_tx();
    t_plain_rx();
    t_fifo_tx();
    t_fifo_rx();
    results();
  end

  initial begin
    #50us;
    fails++;
    results();
  end
endmodule
